// *** design/matbl_pkg.sv ***
// Package for the address table access block: register indices, field positions, reset values, timing.
// Assumes a single 25 MHz switch clock shared by every user of these constants.
package matbl_pkg;
   // ****************************************************************
   // Register indices (printed offsets are word indices)
   // ****************************************************************
   localparam logic [15:0] MATBL_CMD_IDX = 16'h1800;
   localparam logic [15:0] MATBL_WRLO_IDX = 16'h1801;
   localparam logic [15:0] MATBL_WRHI_IDX = 16'h1802;
   localparam logic [15:0] MATBL_STS_IDX = 16'h1803;
   localparam logic [15:0] MATBL_CFG_IDX = 16'h1804;
   localparam logic [15:0] MATBL_RDLO_IDX = 16'h1805;
   localparam logic [15:0] MATBL_RDHI_IDX = 16'h1806;
   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int MATBL_CMD_NEXT = 0;
   localparam int MATBL_CMD_FIRST = 1;
   localparam int MATBL_CMD_MAKE = 2;
   localparam int MATBL_F_VALID = 24;
   localparam int MATBL_F_AGE = 23;
   localparam int MATBL_F_STATIC = 22;
   localparam int MATBL_F_FILTER = 21;
   localparam int MATBL_F_PRIO_LO = 19;
   localparam int MATBL_F_PORT_LO = 16;
   localparam int MATBL_F_EOT = 25;
   localparam int MATBL_STS_MAKE = 0;
   localparam int MATBL_STS_BUSY = 1;
   localparam int MATBL_CFG_DAPRIO = 5;
   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [31:0] MATBL_RST_WORD = 32'h0000_0000;
   localparam logic [2:0] MATBL_RST_CMD = 3'h0;
   localparam logic [24:0] MATBL_RST_WRHI = 25'h000_0000;
   // ****************************************************************
   // Timing: aging tick every half of the 10 minute worst case
   // ****************************************************************
   localparam longint MATBL_CLK_HZ = 25000000;
   localparam longint MATBL_AGE_HALF_S = 300;
   localparam longint MATBL_AGE_TICK_CYC = MATBL_CLK_HZ * MATBL_AGE_HALF_S;
endpackage

// *** design/matbl_core.sv ***
// Address table access block: command registers, table storage, search, aging and lookup.
// Assumes a same-clock register port and a lookup/learn engine on the same clock.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module matbl_core
   import matbl_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter longint AGE_TICK_CYC = MATBL_AGE_TICK_CYC
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [15:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   input wire logic learn_in,
   input wire logic [47:0] learn_mac_in,
   input wire logic [2:0] learn_port_in,
   input wire logic look_in,
   input wire logic [47:0] look_mac_in,
   output logic hit_out,
   output logic drop_out,
   output logic override_out,
   output logic prio_vld_out,
   output logic [1:0] prio_out,
   output logic [2:0] ports_out
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || DEPTH > 1024 || (DEPTH & (DEPTH - 1)) != 0)
         $error("DEPTH must be a power of two between 2 and 1024");
   end

   typedef enum {ST_IDLE, ST_MAKE, ST_SEARCH} matbl_st_t;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Address match over the stored 48-bit key, used by make, learn and lookup
   function automatic logic [DEPTH-1:0] match_vec(input logic [47:0] mac, input logic [DEPTH-1:0] vld,
                                                  input logic [DEPTH-1:0][47:0] tab);
      logic [DEPTH-1:0] m;
      m = '0;
      for (int i = 0; i < DEPTH; i++)
         m[i] = vld[i] && (tab[i] == mac);
      return m;
   endfunction
   function automatic logic [AW-1:0] first_set(input logic [DEPTH-1:0] v);
      logic [AW-1:0] k;
      k = '0;
      for (int i = DEPTH - 1; i >= 0; i--)
         if (v[i])
            k = AW'(i);
      return k;
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   matbl_st_t st_r, st_nxt;
   logic [2:0] cmd_r, cmd_nxt;
   logic [31:0] wrlo_r, wrlo_nxt;
   logic [24:0] wrhi_r, wrhi_nxt;
   logic cfg_daprio_r, cfg_daprio_nxt;
   logic make_pend_r, make_pend_nxt;
   logic [31:0] rdlo_r, rdlo_nxt;
   logic [25:0] rdhi_r, rdhi_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [AW:0] ptr_r, ptr_nxt;
   logic [DEPTH-1:0] vld_r, vld_nxt;
   logic [DEPTH-1:0] stat_r, stat_nxt;
   logic [DEPTH-1:0] age_r, age_nxt;
   logic [DEPTH-1:0][47:0] mac_r, mac_nxt;
   logic [DEPTH-1:0][5:0] attr_r, attr_nxt;
   logic [63:0] tick_cnt_r, tick_cnt_nxt;
   logic hit_r, hit_nxt, drop_r, drop_nxt, ovr_r, ovr_nxt, pv_r, pv_nxt;
   logic [1:0] prio_r, prio_nxt;
   logic [2:0] ports_r, ports_nxt;

   logic wr_cmd, age_tick;
   logic [DEPTH-1:0] mk_hit, ln_hit, lk_hit, rest;
   logic [AW-1:0] lk_idx, slot;
   logic [47:0] mk_mac;

   // Aging tick: one pulse per half period, so an idle entry lives between one and two ticks
   assign age_tick = (tick_cnt_r == 64'(AGE_TICK_CYC - 1));
   assign wr_cmd = wr_in && (addr_in == MATBL_CMD_IDX);
   assign mk_mac = {wrhi_r[15:0], wrlo_r};
   assign mk_hit = match_vec(mk_mac, vld_r, mac_r);
   assign ln_hit = match_vec(learn_mac_in, vld_r, mac_r);
   assign lk_hit = match_vec(look_mac_in, vld_r, mac_r);
   assign lk_idx = first_set(lk_hit);
   // Search mask: entries at or past the read pointer that are valid
   always_comb begin
      rest = '0;
      for (int i = 0; i < DEPTH; i++)
         rest[i] = vld_r[i] && ((AW + 1)'(i) >= ptr_r);
   end

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   // Registers, commands, table writes and aging; learning is dropped in an aging tick cycle, but make and aging can write in one cycle
   always_comb begin
      st_nxt = st_r;
      cmd_nxt = cmd_r;
      wrlo_nxt = wrlo_r;
      wrhi_nxt = wrhi_r;
      cfg_daprio_nxt = cfg_daprio_r;
      make_pend_nxt = make_pend_r;
      rdlo_nxt = rdlo_r;
      rdhi_nxt = rdhi_r;
      ptr_nxt = ptr_r;
      vld_nxt = vld_r;
      stat_nxt = stat_r;
      age_nxt = age_r;
      mac_nxt = mac_r;
      attr_nxt = attr_r;
      tick_cnt_nxt = age_tick ? 64'h0 : tick_cnt_r + 64'h1;
      slot = first_set(~vld_r);
      rdata_nxt = 32'h0;
      if (rd_in) begin
         unique case (addr_in)
            MATBL_CMD_IDX: rdata_nxt = {29'h0, cmd_r};
            MATBL_WRLO_IDX: rdata_nxt = wrlo_r;
            MATBL_WRHI_IDX: rdata_nxt = {7'h0, wrhi_r};
            MATBL_STS_IDX: rdata_nxt = {30'h0, st_r != ST_IDLE, make_pend_r};
            MATBL_CFG_IDX: rdata_nxt = 32'(cfg_daprio_r) << MATBL_CFG_DAPRIO;
            MATBL_RDLO_IDX: rdata_nxt = rdlo_r;
            MATBL_RDHI_IDX: rdata_nxt = {6'h0, rdhi_r};
            default: rdata_nxt = 32'h0;
         endcase
      end
      if (wr_in) begin
         unique case (addr_in)
            MATBL_WRLO_IDX: wrlo_nxt = wdata_in;
            MATBL_WRHI_IDX: wrhi_nxt = wdata_in[24:0];
            MATBL_CFG_IDX: cfg_daprio_nxt = wdata_in[MATBL_CFG_DAPRIO];
            default: ;
         endcase
      end
      // Command bits are plain storage; only a one launches, and only when idle
      if (wr_cmd) begin
         cmd_nxt = wdata_in[2:0];
         if (st_r == ST_IDLE) begin
            if (wdata_in[MATBL_CMD_FIRST]) begin
               ptr_nxt = '0;
               st_nxt = ST_SEARCH;
            end else if (wdata_in[MATBL_CMD_NEXT]) begin
               st_nxt = ST_SEARCH;
            end else if (wdata_in[MATBL_CMD_MAKE]) begin
               make_pend_nxt = 1'b1;
               st_nxt = ST_MAKE;
            end
         end
      end
      // Aging: clear the age mark of dynamic entries each tick, remove those already unmarked
      if (age_tick) begin
         for (int i = 0; i < DEPTH; i++) begin
            if (vld_r[i] && !stat_r[i]) begin
               if (!age_r[i])
                  vld_nxt[i] = 1'b0;
               age_nxt[i] = 1'b0;
            end
         end
      end
      unique case (st_r)
         ST_IDLE: begin
            // Learning refreshes or adds dynamic entries; static ones are left untouched
            if (learn_in && !age_tick) begin
               if (|ln_hit) begin
                  for (int i = 0; i < DEPTH; i++)
                     if (ln_hit[i] && !stat_r[i]) begin
                        age_nxt[i] = 1'b1;
                        attr_nxt[i][2:0] = learn_port_in;
                     end
               end else if (!(&vld_r)) begin
                  vld_nxt[slot] = 1'b1;
                  mac_nxt[slot] = learn_mac_in;
                  stat_nxt[slot] = 1'b0;
                  age_nxt[slot] = 1'b1;
                  attr_nxt[slot] = {3'h0, learn_port_in};
               end
            end
         end
         ST_MAKE: begin
            // Replace a matching entry whatever its origin, else take a free slot
            if (|mk_hit)
               slot = first_set(mk_hit);
            // A full table must not spill a new entry over slot 0
            if ((|mk_hit) || (wrhi_r[MATBL_F_VALID] && !(&vld_r))) begin
               vld_nxt[slot] = wrhi_r[MATBL_F_VALID] && ((|mk_hit) || !(&vld_r));
               mac_nxt[slot] = mk_mac;
               stat_nxt[slot] = wrhi_r[MATBL_F_STATIC];
               age_nxt[slot] = wrhi_r[MATBL_F_AGE];
               attr_nxt[slot] = {wrhi_r[MATBL_F_FILTER], wrhi_r[20:19], wrhi_r[18:16]};
            end
            make_pend_nxt = 1'b0;
            st_nxt = ST_IDLE;
         end
         ST_SEARCH: begin
            // End of table is flagged with the EOT bit set and the valid bit low when nothing remains
            if (|rest) begin
               slot = first_set(rest);
               rdlo_nxt = mac_r[slot][31:0];
               rdhi_nxt = {1'b0, 1'b1, age_r[slot], stat_r[slot], attr_r[slot], mac_r[slot][47:32]};
               ptr_nxt = (AW + 1)'(slot) + 1'b1;
            end else begin
               rdlo_nxt = 32'h0;
               rdhi_nxt = 26'h0 | (26'h1 << MATBL_F_EOT);
               ptr_nxt = (AW + 1)'(DEPTH);
            end
            st_nxt = ST_IDLE;
         end
      endcase
   end

   // Lookup result for the forwarding engine, one cycle after the request
   always_comb begin
      hit_nxt = look_in && (|lk_hit);
      drop_nxt = hit_nxt && attr_r[lk_idx][5];
      ovr_nxt = hit_nxt && stat_r[lk_idx] && age_r[lk_idx];
      pv_nxt = hit_nxt && stat_r[lk_idx] && cfg_daprio_r;
      prio_nxt = pv_nxt ? attr_r[lk_idx][4:3] : 2'h0;
      ports_nxt = 3'h0;
      if (hit_nxt) begin
         unique case (attr_r[lk_idx][2:0])
            3'h0: ports_nxt = 3'h1;
            3'h1: ports_nxt = 3'h2;
            3'h2: ports_nxt = 3'h4;
            3'h4: ports_nxt = 3'h3;
            3'h5: ports_nxt = 3'h5;
            3'h6: ports_nxt = 3'h6;
            3'h7: ports_nxt = 3'h7;
            default: ports_nxt = 3'h0;
         endcase
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_r <= ST_IDLE;
         cmd_r <= MATBL_RST_CMD;
         wrlo_r <= MATBL_RST_WORD;
         wrhi_r <= MATBL_RST_WRHI;
         cfg_daprio_r <= 1'b0;
         make_pend_r <= 1'b0;
         rdlo_r <= MATBL_RST_WORD;
         rdhi_r <= 26'h0;
         rdata_r <= MATBL_RST_WORD;
         ptr_r <= '0;
         vld_r <= '0;
         stat_r <= '0;
         age_r <= '0;
         mac_r <= '0;
         attr_r <= '0;
         tick_cnt_r <= 64'h0;
         hit_r <= 1'b0;
         drop_r <= 1'b0;
         ovr_r <= 1'b0;
         pv_r <= 1'b0;
         prio_r <= 2'h0;
         ports_r <= 3'h0;
      end else begin
         st_r <= st_nxt;
         cmd_r <= cmd_nxt;
         wrlo_r <= wrlo_nxt;
         wrhi_r <= wrhi_nxt;
         cfg_daprio_r <= cfg_daprio_nxt;
         make_pend_r <= make_pend_nxt;
         rdlo_r <= rdlo_nxt;
         rdhi_r <= rdhi_nxt;
         rdata_r <= rdata_nxt;
         ptr_r <= ptr_nxt;
         vld_r <= vld_nxt;
         stat_r <= stat_nxt;
         age_r <= age_nxt;
         mac_r <= mac_nxt;
         attr_r <= attr_nxt;
         tick_cnt_r <= tick_cnt_nxt;
         hit_r <= hit_nxt;
         drop_r <= drop_nxt;
         ovr_r <= ovr_nxt;
         pv_r <= pv_nxt;
         prio_r <= prio_nxt;
         ports_r <= ports_nxt;
      end
   end

   assign rdata_out = rdata_r;
   assign hit_out = hit_r;
   assign drop_out = drop_r;
   assign override_out = ovr_r;
   assign prio_vld_out = pv_r;
   assign prio_out = prio_r;
   assign ports_out = ports_r;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   AST_MAKE_DONE: assert property (@(posedge clk_in) disable iff (!nrst_in)
      st_r == ST_IDLE && wr_cmd && wdata_in[2:0] == 3'h4 |=> make_pend_r ##1 !make_pend_r)
      else $error("make did not complete in two cycles");
   AST_ZERO_NOP: assert property (@(posedge clk_in) disable iff (!nrst_in)
      st_r == ST_IDLE && wr_cmd && wdata_in[2:0] == 3'h0 |=> st_r == ST_IDLE)
      else $error("zero command started an operation");
   AST_FIRST_PTR: assert property (@(posedge clk_in) disable iff (!nrst_in)
      st_r == ST_IDLE && wr_cmd && wdata_in[MATBL_CMD_FIRST] |=> st_r == ST_SEARCH && ptr_r == '0)
      else $error("get-first did not rewind");
   AST_NEXT_LOAD: assert property (@(posedge clk_in) disable iff (!nrst_in)
      st_r == ST_SEARCH && (|rest) |=> rdhi_r[MATBL_F_VALID] && ptr_r > $past(ptr_r))
      else $error("get-next did not advance");
   AST_STATIC_KEEP: assert property (@(posedge clk_in) disable iff (!nrst_in)
      age_tick && vld_r[0] && stat_r[0] && st_r == ST_IDLE |=> vld_r[0])
      else $error("static entry aged out");
   AST_DYN_AGE: assert property (@(posedge clk_in) disable iff (!nrst_in)
      age_tick && vld_r[0] && !stat_r[0] && !age_r[0] && st_r == ST_IDLE |=> !vld_r[0])
      else $error("stale dynamic entry kept");
   AST_FILTER: assert property (@(posedge clk_in) disable iff (!nrst_in)
      drop_out |-> hit_out && $past(look_in))
      else $error("drop without lookup hit");
   AST_PRIO: assert property (@(posedge clk_in) disable iff (!nrst_in)
      prio_vld_out |-> hit_out && cfg_daprio_r)
      else $error("priority used while option off");
   AST_BUSY: assert property (@(posedge clk_in) disable iff (!nrst_in)
      st_r != ST_IDLE && wr_cmd |=> $stable(ptr_r) || $past(st_r) == ST_SEARCH)
      else $error("command taken while busy");
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// Testbench for the address table access block: register tasks, table walks, lookups, learning, aging.
// Assumes the core alone under test, with a short aging tick so that entries expire within the run.
`timescale 1ns/1ps
`default_nettype none
module tb
   import matbl_pkg::*;
;
   // ****************************************************************
   // Signals and constants
   // ****************************************************************
   // Long enough that the made dynamic entry survives the table walk, short enough for the run
   localparam int AGE = 1000;
   localparam logic [47:0] MAC_A = 48'h0a1b_2c3d_4e5f;
   localparam logic [47:0] MAC_B = 48'h1122_3344_5566;
   localparam logic [47:0] MAC_C = 48'h7788_99aa_bbcc;
   localparam logic [2:0] PMASK [8] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7};
   localparam logic [31:0] HI_A = {7'h0, 4'b1011, 2'h1, 3'h4, MAC_A[47:32]};
   localparam logic [31:0] HI_B = {7'h0, 4'b1100, 2'h3, 3'h1, MAC_B[47:32]};
   logic clk_in, nrst_in, wr_in, rd_in, learn_in, look_in;
   logic [15:0] addr_in;
   logic [31:0] wdata_in, rdata_out, rd_v, lo0, hi0, lo1, hi1;
   logic [47:0] learn_mac_in, look_mac_in;
   logic [2:0] learn_port_in, ports_out;
   logic hit_out, drop_out, override_out, prio_vld_out, swap;
   logic [1:0] prio_out;
   int err_total, check_count;

   // Free-running 25 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   // Short aging tick keeps the expiry scenario within a few thousand cycles
   matbl_core #(.DEPTH(16), .AGE_TICK_CYC(AGE)) uut (
      .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
      .rd_in(rd_in), .rdata_out(rdata_out), .learn_in(learn_in), .learn_mac_in(learn_mac_in),
      .learn_port_in(learn_port_in), .look_in(look_in), .look_mac_in(look_mac_in), .hit_out(hit_out),
      .drop_out(drop_out), .override_out(override_out), .prio_vld_out(prio_vld_out),
      .prio_out(prio_out), .ports_out(ports_out));

   // ****************************************************************
   // Access tasks: each starts and ends just after a rising edge
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // Strobe dropped and one idle cycle left, so no signal is assigned twice in one step
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      @(posedge clk_in);
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [15:0] a);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      rd_v = rdata_out;
      @(posedge clk_in);
   endtask

   // Poll busy and make pending under a bounded count
   task automatic idle();
      int n;
      n = 0;
      rd(MATBL_STS_IDX);
      while (rd_v[1:0] !== 2'h0 && n < 100) begin
         n++;
         rd(MATBL_STS_IDX);
      end
      chk({31'h0, n >= 100}, 32'h0, "command never finished");
   endtask

   task automatic make(input logic [47:0] m, input logic [8:0] fl);
      wr(MATBL_WRLO_IDX, m[31:0]);
      wr(MATBL_WRHI_IDX, {7'h0, fl, m[47:32]});
      wr(MATBL_CMD_IDX, 32'h4);
      idle();
      wr(MATBL_CMD_IDX, 32'h0);
   endtask

   task automatic get(input logic [31:0] c);
      wr(MATBL_CMD_IDX, c);
      idle();
      wr(MATBL_CMD_IDX, 32'h0);
   endtask

   // Expected word: hit, drop, override, priority valid, priority, port mask
   task automatic look(input logic [47:0] m, input logic [8:0] exp, input string msg);
      logic [8:0] got;
      look_mac_in <= m;
      look_in <= 1'b1;
      @(posedge clk_in);
      look_in <= 1'b0;
      #1;
      got = {hit_out, drop_out, override_out, prio_vld_out, prio_out, ports_out};
      if (!exp[5]) got[4:3] = 2'h0;
      if (!exp[8]) got[7:0] = 8'h0;
      chk({23'h0, got}, {23'h0, exp}, msg);
      @(posedge clk_in);
   endtask

   task automatic learn(input logic [47:0] m, input logic [2:0] p);
      learn_mac_in <= m;
      learn_port_in <= p;
      learn_in <= 1'b1;
      @(posedge clk_in);
      learn_in <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic finish_test();
      $display("TB: checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Watchdog well beyond the few thousand cycles the sequence needs
   initial begin
      repeat (20000) @(posedge clk_in);
      err_total++;
      $display("[FAIL] t=%0t watchdog expired", $time);
      finish_test();
   end

   // ****************************************************************
   // Stimulus
   // ****************************************************************
   initial begin
      nrst_in = 1'b0;
      addr_in = 16'h0;
      wdata_in = 32'h0;
      wr_in = 1'b0;
      rd_in = 1'b0;
      learn_in = 1'b0;
      learn_mac_in = 48'h0;
      learn_port_in = 3'h0;
      look_in = 1'b0;
      look_mac_in = 48'h0;
      err_total = 0;
      check_count = 0;
      repeat (20) @(posedge clk_in);
      nrst_in <= 1'b1;
      @(posedge clk_in);
      // Reset values, unmapped index, read-back
      rd(MATBL_WRLO_IDX);
      chk(rd_v, MATBL_RST_WORD, "low write word reset");
      rd(MATBL_WRHI_IDX);
      chk(rd_v, 32'h0, "high write word reset");
      rd(MATBL_CMD_IDX);
      chk(rd_v, 32'h0, "command reset");
      rd(16'h1807);
      chk(rd_v, 32'h0, "unmapped read");
      wr(MATBL_WRLO_IDX, 32'hdead_beef);
      rd(MATBL_WRLO_IDX);
      chk(rd_v, 32'hdead_beef, "low write word readback");
      // Every port code on one static entry; each make replaces the previous one
      wr(MATBL_CFG_IDX, 32'h20);
      for (int c = 0; c < 8; c++) begin
         make(MAC_A, {4'b1110, 2'h2, c[2:0]});
         look(MAC_A, {4'b1011, 2'h2, PMASK[c]}, "port code");
      end
      make(MAC_A, {4'b1011, 2'h1, 3'h4});
      look(MAC_A, {4'b1101, 2'h1, 3'h3}, "filtered static");
      make(MAC_B, {4'b1100, 2'h3, 3'h1});
      look(MAC_B, {4'b1000, 2'h0, 3'h2}, "dynamic entry");
      // A zero command write leaves the table alone
      wr(MATBL_WRHI_IDX, {7'h0, 4'b1100, 2'h3, 3'h7, MAC_B[47:32]});
      wr(MATBL_CMD_IDX, 32'h0);
      look(MAC_B, {4'b1000, 2'h0, 3'h2}, "zero command");
      // Walk the table: two valid entries in either order, then end of table
      get(32'h2);
      rd(MATBL_RDLO_IDX);
      lo0 = rd_v;
      rd(MATBL_RDHI_IDX);
      hi0 = rd_v;
      get(32'h1);
      rd(MATBL_RDLO_IDX);
      lo1 = rd_v;
      rd(MATBL_RDHI_IDX);
      hi1 = rd_v;
      swap = (lo0 !== MAC_A[31:0]);
      chk(swap ? lo1 : lo0, MAC_A[31:0], "walk low A");
      chk(swap ? hi1 : hi0, HI_A, "walk high A");
      chk(swap ? lo0 : lo1, MAC_B[31:0], "walk low B");
      chk(swap ? hi0 : hi1, HI_B, "walk high B");
      get(32'h1);
      rd(MATBL_RDHI_IDX);
      chk({30'h0, rd_v[25:24]}, 32'h2, "end of table");
      get(32'h3);
      rd(MATBL_RDLO_IDX);
      chk(rd_v, lo0, "first wins over next");
      // Invalidate by making with the valid bit clear
      make(MAC_B, 9'h0);
      look(MAC_B, 9'h0, "invalidated entry");
      // Learning adds a dynamic entry but cannot touch a static one
      learn(MAC_C, 3'h2);
      look(MAC_C, {4'b1000, 2'h0, 3'h4}, "learned entry");
      learn(MAC_A, 3'h1);
      look(MAC_A, {4'b1101, 2'h1, 3'h3}, "static after learn");
      // Two aging ticks without traffic remove the dynamic entry only
      repeat (2 * AGE + 20) @(posedge clk_in);
      look(MAC_C, 9'h0, "aged entry");
      look(MAC_A, {4'b1101, 2'h1, 3'h3}, "static after aging");
      finish_test();
   end
endmodule
`default_nettype wire
